// ---- src/dvs_consts.vh ----
// Constants for the DAC volume soft-step block.
`ifndef DVS_CONSTS_VH
`define DVS_CONSTS_VH
`define DVS_ADDR_W        5
`define DVS_REG_CTRL      5'h00
`define DVS_REG_LEFT_VOL  5'h04
`define DVS_REG_RIGHT_VOL 5'h08
`define DVS_REG_MASTER    5'h0c
`define DVS_REG_STATUS    5'h10
`define DVS_REG_INPUT_LVL 5'h14
`define DVS_REG_WEAK_HOLD 5'h18
`define DVS_CTRL_RST      14'h0000
`define DVS_VOL_RST       8'h00
`define DVS_LVL_RST       24'h000000
`define DVS_HOLD_RST      6'h00
`define DVS_B_SOFT_OFF    0
`define DVS_B_SLOW        1
`define DVS_B_POWER       2
`define DVS_B_LEFT_ON     3
`define DVS_B_RIGHT_ON    4
`define DVS_F_BIAS        6:5
`define DVS_F_CM          8:7
`define DVS_F_FX          11:9
`define DVS_B_ADC_SOFT    12
`define DVS_B_ADC_SLOW    13
`define DVS_B_VOL_MUTE    7
`define DVS_F_VOL_ATT     6:0
`define DVS_MUTE_IDX      8'h80
`define DVS_STEPS_OCT     8'h0c
`define DVS_LVL_MAX       4'h8
`define DVS_FRAC_SHIFT    16
`define DVS_PD_TIME_CYC   16
`endif

// ---- src/dvs_volume.v ----
// DAC digital volume with soft-stepping, power and effects sequencing.
`timescale 1ns/1ps
`include "dvs_consts.vh"
// Summary of operation
// RULE1: Each channel attenuates 0 to -63.5 dB in 0.5 dB steps.
// RULE2: Each channel has its own mute and setting, independent of the other.
// RULE3: A master volume write sets both channel targets at once.
// RULE4: Soft-stepping moves applied gain one step per sample toward target.
// RULE5: Slow bit makes the ramp one step per two samples.
// RULE6: Read-only done bit shows applied gain equals requested gain.
// RULE7: Soft-step disable makes a new target apply at once.
// RULE8: Host keeps the clock running until the power-down flag reads set.
// RULE9: Power-down flag sets only after ramp to mute and power-down sequence; the code also loads it set at reset.
// RULE10: Effects selection change ramps to mute, switches, ramps back.
// RULE11: At DAC power-up the gain starts muted and ramps up.
// RULE12: At DAC power-down gain ramps to mute before circuitry powers down; the code holds only dac_power_on, the analog enables drop with their ctrl bits.
// RULE13: Two-bit bias current field resets to lowest current.
// RULE14: Two-bit field selects one of four output common-mode levels.
// RULE15: Whole DAC power control plus per-channel analog power controls.
// RULE16: Each input has a 0 to -12 dB level in 1.5 dB steps.
// RULE17: Input levels soft-step with the ADC soft-step rate and enable.
// RULE18: Unselected inputs float by default; option holds them weakly at CM.
// RULE19: Host clears the weak hold for any selected input.
// RULE20: Output is sample times applied gain; mute gives zero; sample-timed.
// RULE21: Ramp to mute steps past lowest attenuation; done clears on change.
module dvs_volume #(
	parameter DW        = 24,
	parameter NIN       = 6,
	parameter PD_CYCLES = `DVS_PD_TIME_CYC
) (
	// Clock and reset.
	input  wire                   clock,
	input  wire                   rst_n,
	// Avalon-MM slave.
	input  wire [`DVS_ADDR_W-1:0] avs_address,
	input  wire                   avs_read,
	input  wire                   avs_write,
	input  wire [31:0]            avs_writedata,
	output reg  [31:0]            avs_readdata,
	output reg                    avs_waitrequest,
	// Sample stream.
	input  wire                   in_valid,
	input  wire [DW-1:0]          in_left,
	input  wire [DW-1:0]          in_right,
	output reg                    out_valid,
	output wire [DW-1:0]          out_left,
	output wire [DW-1:0]          out_right,
	// Analog configuration.
	output reg                    dac_power_on,
	output reg                    dac_left_analog_on,
	output reg                    dac_right_analog_on,
	output reg  [1:0]             dac_bias_sel,
	output reg  [1:0]             output_common_mode_select,
	output reg  [2:0]             effects_select,
	output wire [4*NIN-1:0]       input_gain_stage_level,
	output reg  [NIN-1:0]         weak_cm_hold
);

	localparam S_OFF    = 5'h01;
	localparam S_RUN    = 5'h02;
	localparam S_FXMUTE = 5'h04;
	localparam S_PDMUTE = 5'h08;
	localparam S_PDSEQ  = 5'h10;

	reg  [13:0]      ctrl;
	reg  [7:0]       vol_l;
	reg  [7:0]       vol_r;
	reg  [4*NIN-1:0] lvl;
	reg  [NIN-1:0]   wh;
	reg  [4:0]       state;
	reg  [4:0]       next_state;
	reg  [15:0]      pd_cnt;
	reg              pd_done;
	reg              phase;
	reg              adc_phase;
	reg  [31:0]      rdmux;
	wire [15:0]      appl_all;
	wire [1:0]       done;
	wire [2*DW-1:0]  in_pair;
	wire [2*DW-1:0]  out_pair;
	wire             req;
	wire             force_mute;
	wire             soft_en;
	wire             tick;
	wire             adc_tick;
	wire             both_muted;

	function [15:0] mant;
		input [3:0] k;
		begin
			case (k)
			4'h0: mant = 16'hffff;
			4'h1: mant = 16'hf1a2;
			4'h2: mant = 16'he412;
			4'h3: mant = 16'hd745;
			4'h4: mant = 16'hcb30;
			4'h5: mant = 16'hbfc9;
			4'h6: mant = 16'hb505;
			4'h7: mant = 16'haadc;
			4'h8: mant = 16'ha145;
			4'h9: mant = 16'h9838;
			4'ha: mant = 16'h8fad;
			default: mant = 16'h879c;
			endcase
		end
	endfunction

	assign req        = avs_read | avs_write;
	assign in_pair    = {in_right, in_left};
	assign out_left   = out_pair[DW-1:0];
	assign out_right  = out_pair[2*DW-1:DW];
	assign soft_en    = ~ctrl[`DVS_B_SOFT_OFF];
	assign force_mute = ~state[1];
	// Slow mode lets only every second sample move the gain.
	assign tick       = in_valid & (~ctrl[`DVS_B_SLOW] | phase); // RULE5
	assign adc_tick   = in_valid & (~ctrl[`DVS_B_ADC_SLOW] | adc_phase); // RULE17
	assign both_muted = (appl_all[7:0] == `DVS_MUTE_IDX) &
	                    (appl_all[15:8] == `DVS_MUTE_IDX);

	always @(posedge clock) begin
		if (!rst_n) begin
			phase     <= 1'b0;
			adc_phase <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				phase     <= ~phase;
				adc_phase <= ~adc_phase;
			end
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
			reg  [7:0]         appl;
			reg  [DW-1:0]      o;
			wire [7:0]         vol = (ch == 0) ? vol_l : vol_r;
			// Index 128 sits one step past -63.5 dB and means zero output.
			wire [7:0]         req_idx = vol[`DVS_B_VOL_MUTE] ?
				`DVS_MUTE_IDX : {1'b0, vol[`DVS_F_VOL_ATT]}; // RULE1 RULE2
			wire [7:0]         tgt = force_mute ? `DVS_MUTE_IDX : req_idx;
			wire [7:0]         oct = appl / `DVS_STEPS_OCT;
			wire [7:0]         frc = appl % `DVS_STEPS_OCT;
			wire signed [DW-1:0] s = in_pair[ch*DW +: DW];
			wire signed [16:0] m = {1'b0, mant(frc[3:0])};
			wire signed [DW+16:0] prod = s * m;
			wire signed [DW+16:0] scl = (prod >>> `DVS_FRAC_SHIFT) >>> oct[3:0];
			always @(posedge clock) begin
				if (!rst_n) begin
					appl <= `DVS_MUTE_IDX;
					o    <= {DW{1'b0}};
				end else begin
					if (!soft_en) begin
						if (in_valid)
							appl <= tgt; // RULE7
					end else if (tick && appl != tgt) begin
						if (appl < tgt)
							appl <= appl + 8'h01; // RULE4 RULE21
						else
							appl <= appl - 8'h01; // RULE4
					end
					if (in_valid) begin
						if (appl[7])
							o <= {DW{1'b0}}; // RULE20
						else
							o <= scl[DW-1:0]; // RULE20
					end
				end
			end
			assign appl_all[ch*8 +: 8]  = appl;
			assign done[ch]             = (appl == req_idx); // RULE6 RULE21
			assign out_pair[ch*DW +: DW] = o;
		end
	endgenerate

	genvar ip;
	generate
		for (ip = 0; ip < NIN; ip = ip + 1) begin : g_in
			wire [3:0] raw = lvl[ip*4 +: 4];
			// Codes above the last step are treated as -12 dB.
			wire [3:0] tgt = (raw > `DVS_LVL_MAX) ? `DVS_LVL_MAX : raw; // RULE16
			reg  [3:0] cur;
			always @(posedge clock) begin
				if (!rst_n) begin
					cur <= 4'h0;
				end else if (!ctrl[`DVS_B_ADC_SOFT]) begin
					cur <= tgt;
				end else if (adc_tick && cur != tgt) begin
					if (cur < tgt)
						cur <= cur + 4'h1; // RULE17
					else
						cur <= cur - 4'h1; // RULE17
				end
			end
			assign input_gain_stage_level[ip*4 +: 4] = cur;
		end
	endgenerate

	always @* begin
		next_state = state;
		case (state)
		S_OFF:
			if (ctrl[`DVS_B_POWER])
				next_state = S_RUN; // RULE11
		S_RUN:
			if (!ctrl[`DVS_B_POWER])
				next_state = S_PDMUTE; // RULE12
			else if (ctrl[`DVS_F_FX] != effects_select)
				next_state = S_FXMUTE; // RULE10
		S_FXMUTE:
			if (both_muted)
				next_state = S_RUN; // RULE10
		S_PDMUTE:
			if (both_muted)
				next_state = S_PDSEQ; // RULE12
		S_PDSEQ:
			if (pd_cnt == PD_CYCLES - 1)
				next_state = S_OFF; // RULE9
		default:
			next_state = S_OFF;
		endcase
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			state               <= S_OFF;
			pd_cnt              <= 16'h0000;
			pd_done             <= 1'b1;
			effects_select      <= 3'h0;
			dac_power_on        <= 1'b0;
			dac_left_analog_on  <= 1'b0;
			dac_right_analog_on <= 1'b0;
			dac_bias_sel        <= 2'h0;
			output_common_mode_select <= 2'h0;
			weak_cm_hold        <= `DVS_HOLD_RST;
		end else begin
			state <= next_state;
			if (state == S_PDSEQ)
				pd_cnt <= pd_cnt + 16'h0001;
			else
				pd_cnt <= 16'h0000;
			pd_done <= (next_state == S_OFF); // RULE9
			if (state == S_FXMUTE && both_muted)
				effects_select <= ctrl[`DVS_F_FX]; // RULE10
			// DAC power stays on through the mute ramp; each analog enable also follows its own control bit.
			dac_power_on        <= (next_state != S_OFF); // RULE15 RULE12
			dac_left_analog_on  <= (next_state != S_OFF) &
			                       ctrl[`DVS_B_LEFT_ON]; // RULE15
			dac_right_analog_on <= (next_state != S_OFF) &
			                       ctrl[`DVS_B_RIGHT_ON]; // RULE15
			dac_bias_sel        <= ctrl[`DVS_F_BIAS]; // RULE13
			output_common_mode_select <= ctrl[`DVS_F_CM]; // RULE14
			weak_cm_hold        <= wh; // RULE18
		end
	end

	always @* begin
		rdmux = 32'h00000000;
		case (avs_address)
		`DVS_REG_CTRL:      rdmux[13:0] = ctrl;
		`DVS_REG_LEFT_VOL:  rdmux[7:0]  = vol_l;
		`DVS_REG_RIGHT_VOL: rdmux[7:0]  = vol_r;
		`DVS_REG_MASTER:    rdmux[7:0]  = vol_l;
		`DVS_REG_STATUS:    rdmux[2:0]  = {pd_done, done}; // RULE6 RULE9
		`DVS_REG_INPUT_LVL: rdmux[4*NIN-1:0] = lvl;
		`DVS_REG_WEAK_HOLD: rdmux[NIN-1:0]   = wh;
		default:            rdmux = 32'h00000000;
		endcase
	end

	// One wait cycle keeps read data registered ahead of the completing edge.
	always @(posedge clock) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
			ctrl            <= `DVS_CTRL_RST; // RULE13
			vol_l           <= `DVS_VOL_RST;
			vol_r           <= `DVS_VOL_RST;
			lvl             <= `DVS_LVL_RST;
			wh              <= `DVS_HOLD_RST; // RULE18
		end else begin
			avs_waitrequest <= 1'b1;
			if (req && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata    <= rdmux;
			end
			if (avs_write && !avs_waitrequest) begin
				case (avs_address)
				`DVS_REG_CTRL:      ctrl  <= avs_writedata[13:0];
				`DVS_REG_LEFT_VOL:  vol_l <= avs_writedata[7:0]; // RULE2
				`DVS_REG_RIGHT_VOL: vol_r <= avs_writedata[7:0]; // RULE2
				`DVS_REG_MASTER: begin
					vol_l <= avs_writedata[7:0]; // RULE3
					vol_r <= avs_writedata[7:0]; // RULE3
				end
				`DVS_REG_INPUT_LVL: lvl <= avs_writedata[4*NIN-1:0];
				`DVS_REG_WEAK_HOLD: wh  <= avs_writedata[NIN-1:0];
				default: ;
				endcase
			end
		end
	end

endmodule

// ---- tb/dvs_volume_asserts.sv ----
// Port checker for the DAC volume block.
`timescale 1ns/1ps
module dvs_volume_asserts #(
	parameter DW = 24
) (
	input wire          clock,
	input wire          rst_n,
	input wire          avs_read,
	input wire          avs_write,
	input wire          avs_waitrequest,
	input wire          in_valid,
	input wire          out_valid,
	input wire [DW-1:0] out_left,
	input wire [DW-1:0] out_right,
	input wire          dac_power_on,
	input wire          dac_left_analog_on,
	input wire          dac_right_analog_on
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ans;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	AST_BUS_ANSWER: assert property (s_req |=> s_ans)
		else $error("bus answer late");
	AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	AST_OUT_VALID: assert property (in_valid |=> out_valid)
		else $error("sample not answered");
	AST_NO_EXTRA: assert property (!in_valid |=> !out_valid)
		else $error("spurious output sample");
	AST_OUT_HOLD: assert property (!in_valid |=> $stable(out_left)
		&& $stable(out_right)) else $error("output moved between samples");
	AST_LEFT_PWR: assert property (dac_left_analog_on |-> dac_power_on)
		else $error("left analog on while dac off");
	AST_RIGHT_PWR: assert property (dac_right_analog_on |-> dac_power_on)
		else $error("right analog on while dac off");
	AST_OFF_SILENT: assert property (out_valid && !dac_power_on
		|-> out_left == 0 && out_right == 0) else $error("sound while off");
endmodule
bind dvs_volume dvs_volume_asserts #(.DW(DW)) u_chk (.clock(clock),
	.rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
	.out_valid(out_valid), .out_left(out_left), .out_right(out_right),
	.dac_power_on(dac_power_on), .dac_left_analog_on(dac_left_analog_on),
	.dac_right_analog_on(dac_right_analog_on));

// ---- tb/dvs_src.sv ----
// Audio sample source standing in for the serial interface.
`timescale 1ns/1ps
module dvs_src #(
	parameter DW  = 24,
	parameter GAP = 4
) (
	input  wire          clock,
	input  wire          rst_n,
	input  wire          en,
	output reg           in_valid,
	output reg  [DW-1:0] in_left,
	output reg  [DW-1:0] in_right
);
	reg [7:0] cnt;
	wire      fire = en && cnt == 8'h00;
	// Data outside a sample is inverted so stale values are never trusted.
	always @(posedge clock) begin
		cnt      <= (!rst_n || cnt == GAP - 1) ? 8'h00 : cnt + 8'h01;
		in_valid <= rst_n && fire;
		in_left  <= fire ? 24'h100000 : ~24'h100000;
		in_right <= fire ? 24'h080000 : ~24'h080000;
	end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the DAC volume block.
`timescale 1ns/1ps
`include "dvs_consts.vh"
module tb;
	reg         clock = 0, rst_n = 0, avs_read = 0, avs_write = 0, src_en = 0;
	reg  [4:0]  avs_address = 5'h00;
	reg  [31:0] avs_writedata = 32'h0;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest, in_valid, out_valid, dac_power_on, lon, ron;
	wire [23:0] in_left, in_right, out_left, out_right, lvl;
	wire [1:0]  bias, cms;
	wire [5:0]  hold;
	wire [2:0]  fx;
	integer     fails = 0, comparisons = 0;
	dvs_volume #(.PD_CYCLES(2)) dut (.clock(clock), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.in_valid(in_valid), .in_left(in_left), .in_right(in_right),
		.out_valid(out_valid), .out_left(out_left), .out_right(out_right),
		.dac_power_on(dac_power_on), .dac_left_analog_on(lon),
		.dac_right_analog_on(ron), .dac_bias_sel(bias),
		.output_common_mode_select(cms), .effects_select(fx),
		.input_gain_stage_level(lvl), .weak_cm_hold(hold));
	dvs_src src (.clock(clock), .rst_n(rst_n), .en(src_en),
		.in_valid(in_valid), .in_left(in_left), .in_right(in_right));
	initial forever #20 clock = ~clock;
	task chk(input [31:0] got, input [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task acc(input w, input [4:0] a, input [31:0] d);
		@(posedge clock);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		if (!w) chk(avs_readdata, d);
		avs_write <= 0;
		avs_read  <= 0;
	endtask
	task smp(input integer n);
		// A sample launched at the calling edge must not be counted.
		@(negedge clock);
		repeat (n) @(posedge out_valid);
		@(negedge clock);
	endtask
	task final_report;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clock);
		rst_n  <= 1;
		src_en <= 1;
		acc(0, `DVS_REG_CTRL, 32'h0);
		acc(0, `DVS_REG_STATUS, 32'h4);
		chk(bias, 2'b00);
		acc(1, `DVS_REG_CTRL, 32'h17c);
		acc(1, `DVS_REG_MASTER, 32'h02);
		chk({bias, cms}, 4'hf & 4'b1110);
		smp(60);
		chk({dac_power_on, lon, ron}, 3'b111);
		acc(0, `DVS_REG_STATUS, 32'h0);
		smp(70);
		acc(0, `DVS_REG_STATUS, 32'h3);
		acc(0, `DVS_REG_RIGHT_VOL, 32'h02);
		acc(1, `DVS_REG_CTRL, 32'h17e);
		acc(1, `DVS_REG_LEFT_VOL, 32'h00);
		smp(2);
		acc(0, `DVS_REG_STATUS, 32'h2);
		smp(4);
		acc(0, `DVS_REG_STATUS, 32'h3);
		smp(1);
		chk(out_left, 24'h0ffff0);
		acc(1, `DVS_REG_CTRL, 32'h17d);
		acc(1, `DVS_REG_LEFT_VOL, 32'h80);
		smp(1);
		acc(0, `DVS_REG_STATUS, 32'h3);
		smp(1);
		chk(out_left, 24'h0);
		acc(1, `DVS_REG_CTRL, 32'h0);
		smp(20);
		chk(lon, 1'b0);
		acc(0, `DVS_REG_STATUS, 32'h1);
		// Clock keeps running until the power-down flag is seen.
		smp(130);
		repeat (8) @(posedge clock);
		acc(0, `DVS_REG_STATUS, 32'h5);
		chk(dac_power_on, 1'b0);
		acc(1, `DVS_REG_INPUT_LVL, 32'h8);
		smp(1);
		chk(lvl, 24'h000008);
		acc(0, `DVS_REG_INPUT_LVL, 32'h8);
		acc(1, `DVS_REG_CTRL, 32'h1000);
		acc(1, `DVS_REG_INPUT_LVL, 32'h0);
		smp(3);
		chk(lvl, 24'h000005);
		acc(1, `DVS_REG_WEAK_HOLD, 32'h21);
		acc(0, `DVS_REG_WEAK_HOLD, 32'h21);
		chk(hold, 6'h21);
		// Input 0 is taken into use, so its weak hold is dropped first.
		acc(1, `DVS_REG_WEAK_HOLD, 32'h20);
		smp(1);
		chk(hold, 6'h20);
		acc(1, `DVS_REG_MASTER, 32'h7e);
		acc(1, `DVS_REG_CTRL, 32'h1004);
		smp(4);
		acc(0, `DVS_REG_STATUS, 32'h3);
		acc(1, `DVS_REG_CTRL, 32'h1204);
		smp(8);
		chk(fx, 3'h1);
		acc(0, `DVS_REG_STATUS, 32'h3);
		smp(1);
		chk(out_left, 24'h0002d4);
		chk(out_right, 24'h00016a);
		acc(0, 5'h1c, 32'h0);
		final_report;
	end
	// Whole run needs about 300 samples of 4 cycles at most.
	initial begin
		repeat (20000) @(posedge clock);
		fails = fails + 1;
		final_report;
	end
endmodule
